// ### rtl/slice_defs.vh
// Constants for the programmable logic cluster: register map, fields, modes.
// Assumes a 32-bit APB slave with byte addresses on paddr[7:0].
//
// What this block does
// - Cluster of four slices, two columns of two, two carry chains, one shift chain.
// - Each slice has two 4-input generators, carry, arithmetic gates, wide muxes, two storage.
// - Each generator works as lookup table, 16-bit memory or variable-tap shift register.
// - Lookup table mode gives any boolean function of its four inputs.
// - Generator output drives the slice output and the storage data input.
// - Five-input stage plus wider stage of six, seven or eight inputs by position.
// - Five-input stage lets one slice build selected nine-input functions.
// - Each storage element is an edge flip-flop or a level latch.
// - Storage data comes from the generator path or a bypassing direct input.
// - Clock enable active high by default; unused means always enabled.
// - Set/reset forces 1 under force-high attribute, 0 under force-low.
// - Optional second input forces the opposite state while set/reset is in use.
// - Reset wins when reset and set act together.
// - Initial value follows force attribute by default, or an independent setting.
// - Set and reset are synchronous or asynchronous per slice.
// - Clock, enable and set/reset are shared by both storage elements.
// - Every shared control input has its own programmable polarity.
`ifndef SLICE_DEFS_VH
`define SLICE_DEFS_VH

// ==========================================
// Register map (byte addresses)
`define FG_BASE          8'h00
`define FG_LAST          8'h1C
`define CFG_BASE         8'h20
`define CFG_LAST         8'h2C
`define STATUS_OFFSET    8'h30
`define CFG_RESET        26'h0000000
`define FG_RESET         16'h0000

// ==========================================
// Generator modes
`define MODE_LUT         2'h0
`define MODE_RAM         2'h1
`define MODE_SHIFT       2'h2

// ==========================================
// Slice configuration fields
`define F_MODE_LO        0
`define G_MODE_LO        2
`define F_CASCADE        4
`define G_CASCADE        5
`define LATCH_MODE       6
`define SYNC_FORCE       7
`define FORCE_HIGH_X     8
`define FORCE_HIGH_Y     9
`define INIT_INDEP       10
`define INIT_X           11
`define INIT_Y           12
`define OPP_ENABLE       13
`define CE_USED          14
`define CLK_INV          15
`define CE_INV           16
`define FORCE_INV        17
`define OPP_INV          18
`define BYPASS_X         19
`define BYPASS_Y         20
`define X_SRC_LO         21
`define Y_SRC_LO         23
`define GEN_AND          25

// ==========================================
// Output source codes
`define SRC_LUT          2'h0
`define SRC_WIDE         2'h1
`define SRC_SUM          2'h2

`endif

// ### rtl/function_generator.v
// One 4-input function generator: lookup table, 16-bit memory or shift register.
// Assumes wr_en is already qualified by the slice clock edge and enable.
`timescale 1ns/1ps
`include "slice_defs.vh"

module function_generator (
    input  wire        pclk,
    input  wire        presetn,
    input  wire [1:0]  mode,
    input  wire [3:0]  addr,
    input  wire        din,
    input  wire        wr_en,
    input  wire        cfg_we,
    input  wire [15:0] cfg_data,
    output wire        lut_out,
    output wire        shift_msb,
    output wire [15:0] content
);

    reg [15:0] mem;

    // ==========================================
    // Contents: loaded by software, written or shifted by fabric
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem <= `FG_RESET;
        end else if (cfg_we) begin
            mem <= cfg_data;
        end else if (wr_en) begin
            case (mode)
                `MODE_RAM:   mem[addr] <= din;
                `MODE_SHIFT: mem <= {mem[14:0], din};
                default:     mem <= mem;
            endcase
        end
    end

    // Table read, memory read and shift tap share one selector
    assign lut_out   = mem[addr];
    assign shift_msb = mem[15];
    assign content   = mem;

endmodule

// ### rtl/logic_cluster.v
// Logic cluster of four slices with an APB port for configuration and state.
// Assumes all fabric inputs are driven from logic on pclk.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "slice_defs.vh"

module logic_cluster (
    input  wire        pclk,
    input  wire        presetn,
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [15:0] f_in,
    input  wire [15:0] g_in,
    input  wire [3:0]  first_direct_input,
    input  wire [3:0]  second_direct_input,
    input  wire [3:0]  slice_clk,
    input  wire [3:0]  slice_ce,
    input  wire [3:0]  set_reset_input,
    input  wire [3:0]  slice_we,
    input  wire        global_init,
    input  wire [1:0]  carry_in,
    input  wire        shift_in,
    input  wire        wide_ext_in,
    output wire [3:0]  out_x,
    output wire [3:0]  out_y,
    output wire [3:0]  q_x,
    output wire [3:0]  q_y,
    output wire [1:0]  carry_out,
    output wire        shift_out,
    output wire        wide_f7_out
);

    // ==========================================
    // Decoding helpers
    localparam KIND_NONE   = 2'h0;
    localparam KIND_FG     = 2'h1;
    localparam KIND_CFG    = 2'h2;
    localparam KIND_STATUS = 2'h3;

    function [1:0] reg_kind;
        input [7:0] a;
        begin
            if (a[1:0] != 2'h0)
                reg_kind = KIND_NONE;
            else if (a <= `FG_LAST)
                reg_kind = KIND_FG;
            else if (a >= `CFG_BASE && a <= `CFG_LAST)
                reg_kind = KIND_CFG;
            else if (a == `STATUS_OFFSET)
                reg_kind = KIND_STATUS;
            else
                reg_kind = KIND_NONE;
        end
    endfunction

    // Reset beats set beats load
    function elem_next;
        input q;
        input d;
        input take;
        input rst;
        input set;
        begin
            if (rst)
                elem_next = 1'b0;
            else if (set)
                elem_next = 1'b1;
            else if (take)
                elem_next = d;
            else
                elem_next = q;
        end
    endfunction

    function out_pick;
        input [1:0] src;
        input       lut;
        input       wide;
        input       sum;
        begin
            case (src)
                `SRC_WIDE: out_pick = wide;
                `SRC_SUM:  out_pick = sum;
                default:   out_pick = lut;
            endcase
        end
    endfunction

    // ==========================================
    // APB slave
    reg  [25:0]  slice_cfg [0:3];
    wire [127:0] fg_content;
    wire [1:0]   wr_kind;
    wire [1:0]   acc_kind;
    wire         wr_go;
    reg          init_pending;
    integer      i;

    assign acc_kind = reg_kind(paddr);
    assign wr_kind  = (psel && penable && pwrite) ? acc_kind : KIND_NONE;
    assign wr_go    = psel && penable && pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && (acc_kind == KIND_NONE);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < 4; i = i + 1) begin
                slice_cfg[i] <= `CFG_RESET;
            end
        end else if (wr_go && wr_kind == KIND_CFG) begin
            slice_cfg[paddr[3:2]] <= pwdata[25:0];
        end
    end

    // Read data caught in the setup cycle, shown in the access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (acc_kind)
                KIND_FG:     prdata <= {16'h0000, fg_content[paddr[4:2]*16 +: 16]};
                KIND_CFG:    prdata <= {6'h00, slice_cfg[paddr[3:2]]};
                KIND_STATUS: prdata <= {24'h000000, q_y, q_x};
                default:     prdata <= 32'h00000000;
            endcase
        end
    end

    // Initial values load once after reset release and on global_init
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_pending <= 1'b1;
        end else begin
            init_pending <= 1'b0;
        end
    end

    // ==========================================
    // Cluster-wide chains
    wire [7:0] fg_lut;
    wire [7:0] fg_msb;
    wire [7:0] chain_prev;
    wire [3:0] slice_cin;
    wire [3:0] slice_cout;
    wire [3:0] f5;
    wire [3:0] fx;

    // Shift chain runs through all eight generators in order
    assign chain_prev = {fg_msb[6:0], shift_in};
    assign shift_out  = fg_msb[7];

    // Two columns: slices 0-1 and slices 2-3
    assign slice_cin[0] = carry_in[0];
    assign slice_cin[1] = slice_cout[0];
    assign slice_cin[2] = carry_in[1];
    assign slice_cin[3] = slice_cout[2];
    assign carry_out    = {slice_cout[3], slice_cout[1]};

    // Wide stage by position: six at 0 and 2, seven at 1, eight at 3
    assign fx[0] = second_direct_input[0] ? f5[1] : f5[0];
    assign fx[2] = second_direct_input[2] ? f5[3] : f5[2];
    assign fx[1] = second_direct_input[1] ? fx[2] : fx[0];
    assign fx[3] = second_direct_input[3] ? wide_ext_in : fx[1];
    assign wide_f7_out = fx[1];

    // ==========================================
    // Slices
    genvar s;
    generate
        for (s = 0; s < 4; s = s + 1) begin : slice
            wire [25:0] cfg = slice_cfg[s];
            wire [1:0]  f_mode = cfg[`F_MODE_LO +: 2];
            wire [1:0]  g_mode = cfg[`G_MODE_LO +: 2];
            wire [3:0]  fa = f_in[4*s +: 4];
            wire [3:0]  ga = g_in[4*s +: 4];
            wire        dir_a = first_direct_input[s];
            wire        dir_b = second_direct_input[s];
            reg         clk_prev;
            reg         qx;
            reg         qy;

            // Shared controls, each with its own polarity
            wire clk_lvl = slice_clk[s] ^ cfg[`CLK_INV];
            wire edge_hit = clk_lvl && !clk_prev;
            wire ce_eff = !cfg[`CE_USED] || (slice_ce[s] ^ cfg[`CE_INV]);
            wire force_in = set_reset_input[s] ^ cfg[`FORCE_INV];
            wire opp_in = cfg[`OPP_ENABLE] && (dir_b ^ cfg[`OPP_INV]);
            wire wr_en = edge_hit && ce_eff && slice_we[s];

            // Shift input from the chain or from the direct input
            wire f_din = (f_mode == `MODE_SHIFT && cfg[`F_CASCADE]) ? chain_prev[2*s] : dir_a;
            wire g_din = (g_mode == `MODE_SHIFT && cfg[`G_CASCADE]) ? chain_prev[2*s+1] : dir_b;

            function_generator u_fg_f (
                .pclk      (pclk),
                .presetn   (presetn),
                .mode      (f_mode),
                .addr      (fa),
                .din       (f_din),
                .wr_en     (wr_en),
                .cfg_we    (wr_kind == KIND_FG && paddr[4:2] == 2*s),
                .cfg_data  (pwdata[15:0]),
                .lut_out   (fg_lut[2*s]),
                .shift_msb (fg_msb[2*s]),
                .content   (fg_content[32*s +: 16])
            );

            function_generator u_fg_g (
                .pclk      (pclk),
                .presetn   (presetn),
                .mode      (g_mode),
                .addr      (ga),
                .din       (g_din),
                .wr_en     (wr_en),
                .cfg_we    (wr_kind == KIND_FG && paddr[4:2] == 2*s+1),
                .cfg_data  (pwdata[15:0]),
                .lut_out   (fg_lut[2*s+1]),
                .shift_msb (fg_msb[2*s+1]),
                .content   (fg_content[32*s+16 +: 16])
            );

            // Five-input stage selects between the two generators
            assign f5[s] = dir_a ? fg_lut[2*s+1] : fg_lut[2*s];

            // Carry and arithmetic gates
            wire gen_f = cfg[`GEN_AND] ? (fa[0] & fa[1]) : fa[0];
            wire gen_g = cfg[`GEN_AND] ? (ga[0] & ga[1]) : ga[0];
            wire co_f = fg_lut[2*s] ? slice_cin[s] : gen_f;
            assign slice_cout[s] = fg_lut[2*s+1] ? co_f : gen_g;
            wire sum_f = fg_lut[2*s] ^ slice_cin[s];
            wire sum_g = fg_lut[2*s+1] ^ co_f;

            // Slice outputs and the storage paths
            wire lut_path_upper = out_pick(cfg[`X_SRC_LO +: 2], fg_lut[2*s], f5[s], sum_f);
            wire lut_path_lower = out_pick(cfg[`Y_SRC_LO +: 2], fg_lut[2*s+1], fx[s], sum_g);
            assign out_x[s] = lut_path_upper;
            assign out_y[s] = lut_path_lower;
            wire d_upper = cfg[`BYPASS_X] ? dir_a : lut_path_upper;
            wire d_lower = cfg[`BYPASS_Y] ? dir_b : lut_path_lower;

            // Flip-flop takes on the edge, latch while the gate is open
            wire take = cfg[`LATCH_MODE] ? (clk_lvl && ce_eff) : (edge_hit && ce_eff);
            wire force_win = !cfg[`SYNC_FORCE] ||
                             (cfg[`LATCH_MODE] ? clk_lvl : edge_hit);

            wire hx = cfg[`FORCE_HIGH_X];
            wire hy = cfg[`FORCE_HIGH_Y];
            wire rst_x = force_win && ((force_in && !hx) || (opp_in && hx));
            wire set_x = force_win && ((force_in && hx) || (opp_in && !hx));
            wire rst_y = force_win && ((force_in && !hy) || (opp_in && hy));
            wire set_y = force_win && ((force_in && hy) || (opp_in && !hy));

            wire init_x = cfg[`INIT_INDEP] ? cfg[`INIT_X] : hx;
            wire init_y = cfg[`INIT_INDEP] ? cfg[`INIT_Y] : hy;

            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    clk_prev <= 1'b0;
                    qx       <= 1'b0;
                    qy       <= 1'b0;
                end else begin
                    clk_prev <= clk_lvl;
                    if (init_pending || global_init) begin
                        qx <= init_x;
                        qy <= init_y;
                    end else begin
                        qx <= elem_next(qx, d_upper, take, rst_x, set_x);
                        qy <= elem_next(qy, d_lower, take, rst_y, set_y);
                    end
                end
            end

            assign q_x[s] = qx;
            assign q_y[s] = qy;
        end
    endgenerate

endmodule

// ### sim/slice_clock_source.sv
// Fabric-side model that makes the per-slice clock levels.
// Assumes the bench asks for an edge with a one-cycle toggle mask.
`timescale 1ns/1ps

module slice_clock_source (
    input  wire       pclk,
    input  wire       presetn,
    input  wire [3:0] toggle,
    output reg  [3:0] slice_clk
);
    // Levels stand still unless an edge is asked for
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slice_clk <= 4'h0;
        end else begin
            slice_clk <= slice_clk ^ toggle;
        end
    end
endmodule

// ### sim/logic_cluster_properties.sv
// Checker for slice 0 storage and table behaviour of the logic cluster.
// Assumes slice 0 F stays in table mode, shadowed from APB writes.
`timescale 1ns/1ps
`include "slice_defs.vh"

module logic_cluster_properties (
    input wire        pclk,
    input wire        presetn,
    input wire [7:0]  paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire [15:0] f_in,
    input wire [3:0]  first_direct_input,
    input wire [3:0]  second_direct_input,
    input wire [3:0]  slice_clk,
    input wire [3:0]  slice_ce,
    input wire [3:0]  set_reset_input,
    input wire        global_init,
    input wire [3:0]  out_x,
    input wire [3:0]  q_x
);
    // ==========================================
    // Shadow of slice 0 settings
    logic [25:0] cfg0;
    logic [15:0] fg0;
    wire         wr_hit = psel && penable && pwrite;
    wire         force_on = set_reset_input[0] ^ cfg0[`FORCE_INV];
    wire         opp_on = cfg0[`OPP_ENABLE] && (second_direct_input[0] ^ cfg0[`OPP_INV]);
    wire         ce_on  = !cfg0[`CE_USED] || (slice_ce[0] ^ cfg0[`CE_INV]);
    wire         quiet  = !force_on && !opp_on && !global_init && !cfg0[`LATCH_MODE];
    wire         xlut   = cfg0[22:21] == `SRC_LUT;
    wire         d0     = cfg0[`BYPASS_X] ? first_direct_input[0] : out_x[0];
    wire         power_up_low_attr  = cfg0[`INIT_INDEP] ? cfg0[`INIT_X] : cfg0[`FORCE_HIGH_X];
    wire         async  = !cfg0[`SYNC_FORCE] && force_on && !global_init;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg0 <= `CFG_RESET;
            fg0  <= `FG_RESET;
        end else begin
            if (wr_hit && paddr == `CFG_BASE) begin
                cfg0 <= pwdata[25:0];
            end
            if (wr_hit && paddr == `FG_BASE) begin
                fg0 <= pwdata[15:0];
            end
        end
    end

    // ==========================================
    // Properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_table;
        cfg0[1:0] == `MODE_LUT && xlut |-> out_x[0] == fg0[f_in[3:0]];
    endproperty
    a_table: assert property (p_table) else $error("table output differs");
    property p_take;
        quiet && ce_on && !cfg0[`CLK_INV] && xlut && $rose(slice_clk[0]) |=> q_x[0] == $past(d0);
    endproperty
    a_take: assert property (p_take) else $error("flop missed its data");
    property p_inv;
        quiet && ce_on && cfg0[`CLK_INV] && xlut && $fell(slice_clk[0]) |=> q_x[0] == $past(d0);
    endproperty
    a_inv: assert property (p_inv) else $error("inverted clock edge missed");
    property p_hold;
        quiet && cfg0[`CE_USED] && !ce_on |=> $stable(q_x[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("flop moved while disabled");
    property p_set;
        async && !opp_on && cfg0[`FORCE_HIGH_X] |=> q_x[0];
    endproperty
    a_set: assert property (p_set) else $error("force high failed");
    property p_clear;
        async && !opp_on && !cfg0[`FORCE_HIGH_X] |=> !q_x[0];
    endproperty
    a_clear: assert property (p_clear) else $error("force low failed");
    property p_both;
        async && opp_on |=> !q_x[0];
    endproperty
    a_both: assert property (p_both) else $error("reset did not win");
    property p_init;
        global_init |=> q_x[0] == $past(power_up_low_attr);
    endproperty
    a_init: assert property (p_init) else $error("initial value wrong");
endmodule

// ### sim/logic_cluster_tb_top.sv
// Testbench for the logic cluster: APB set-up, fabric stimulus, self checks.
// Assumes the checker and the slice clock model are compiled before it.
`timescale 1ns/1ps
`include "slice_defs.vh"

module logic_cluster_tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] f_in = 16'h0;
    logic [3:0]  first_direct_input = 4'h0;
    logic [3:0]  second_direct_input = 4'h0;
    logic [3:0]  slice_ce = 4'h0;
    logic [3:0]  set_reset_input = 4'h0;
    logic [3:0]  slice_we = 4'h0;
    logic [3:0]  tog = 4'h0;
    logic        global_init = 1'b0;
    logic [31:0] prdata, rdv;
    logic        pready, pslverr, errv;
    logic [3:0]  slice_clk, out_x, q_x;
    logic [1:0]  carry_in = 2'h0;
    logic [1:0]  carry_out;
    logic        shift_out, wide_f7_out;
    int          errors = 0;
    int          total_checks = 0;
    int          cycles = 0;

    always #12.5 pclk = ~pclk;

    slice_clock_source fabric (.pclk(pclk), .presetn(presetn), .toggle(tog), .slice_clk(slice_clk));

    logic_cluster dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .f_in(f_in), .g_in(16'h0000), .first_direct_input(first_direct_input),
        .second_direct_input(second_direct_input), .slice_clk(slice_clk), .slice_ce(slice_ce),
        .set_reset_input(set_reset_input), .slice_we(slice_we), .global_init(global_init),
        .carry_in(carry_in), .shift_in(1'b0), .wide_ext_in(1'b0), .out_x(out_x), .out_y(),
        .q_x(q_x), .q_y(), .carry_out(carry_out), .shift_out(shift_out),
        .wide_f7_out(wide_f7_out));

    // ==========================================
    // Tasks
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("read data", e, rdv);
    endtask

    task automatic qchk(input logic e);
        chk("q_x0", {31'h0, e}, {31'h0, q_x[0]});
    endtask

    task automatic pulse(input logic [3:0] m);
        tog <= m;
        @(posedge pclk);
        tog <= 4'h0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic force_q(input logic rv, input logic e);
        set_reset_input <= 4'h1;
        second_direct_input <= {3'h0, rv};
        repeat (2) @(posedge pclk);
        qchk(e);
        set_reset_input <= 4'h0;
        second_direct_input <= 4'h0;
        @(posedge pclk);
    endtask

    task automatic ginit();
        global_init <= 1'b1;
        @(posedge pclk);
        global_init <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    function automatic logic [31:0] b(input int i);
        return 32'h1 << i;
    endfunction

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            report_and_stop();
        end
    end

    // ==========================================
    // Tests
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(`CFG_BASE, 32'h0);
        rchk(`STATUS_OFFSET, 32'h0);
        rchk(8'h34, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, errv});
        $display("register test done");
        apb(1'b1, `FG_BASE, 32'h0000A5C3);
        for (int i = 0; i < 16; i++) begin
            f_in <= i[15:0];
            @(posedge pclk);
            chk("table", (32'h0000A5C3 >> i) & 32'h1, {31'h0, out_x[0]});
        end
        f_in <= 16'h0;
        pulse(4'h1);
        qchk(1'b1);
        apb(1'b1, `CFG_BASE, b(`CE_USED));
        f_in <= 16'h2;
        pulse(4'h1);
        pulse(4'h1);
        qchk(1'b1);
        apb(1'b1, `CFG_BASE, b(`CE_USED) | b(`CE_INV));
        pulse(4'h1);
        pulse(4'h1);
        qchk(1'b0);
        apb(1'b1, `CFG_BASE, b(`CLK_INV) | b(`BYPASS_X));
        first_direct_input <= 4'h1;
        pulse(4'h1);
        qchk(1'b1);
        $display("storage test done");
        apb(1'b1, `CFG_BASE, 32'h0);
        force_q(1'b0, 1'b0);
        apb(1'b1, `CFG_BASE, b(`FORCE_HIGH_X));
        force_q(1'b0, 1'b1);
        apb(1'b1, `CFG_BASE, b(`FORCE_HIGH_X) | b(`OPP_ENABLE));
        force_q(1'b1, 1'b0);
        apb(1'b1, `CFG_BASE, b(`FORCE_HIGH_X) | b(`SYNC_FORCE));
        set_reset_input <= 4'h1;
        repeat (2) @(posedge pclk);
        qchk(1'b0);
        pulse(4'h1);
        qchk(1'b1);
        set_reset_input <= 4'h0;
        $display("set reset test done");
        apb(1'b1, `CFG_BASE, b(`FORCE_HIGH_X) | b(`INIT_INDEP));
        ginit();
        qchk(1'b0);
        apb(1'b1, `CFG_BASE, b(`FORCE_HIGH_X));
        ginit();
        qchk(1'b1);
        rchk(`STATUS_OFFSET, 32'h00000001);
        $display("initial value test done");
        apb(1'b1, `CFG_BASE + 8'h04, {30'h0, `MODE_RAM});
        f_in <= 16'h0050;
        first_direct_input <= 4'h2;
        slice_we <= 4'h2;
        pulse(4'h2);
        rchk(`FG_BASE + 8'h08, 32'h00000020);
        slice_we <= 4'h0;
        f_in <= 16'h0060;
        pulse(4'h2);
        pulse(4'h2);
        rchk(`FG_BASE + 8'h08, 32'h00000020);
        $display("memory test done");
        apb(1'b1, `CFG_BASE, b(`LATCH_MODE) | b(`BYPASS_X));
        repeat (2) @(posedge pclk);
        qchk(1'b0);
        pulse(4'h1);
        first_direct_input <= 4'h1;
        repeat (2) @(posedge pclk);
        qchk(1'b0);
        $display("latch test done");
        apb(1'b1, `FG_BASE + 8'h10, 32'h00000001);
        apb(1'b1, `FG_BASE + 8'h14, 32'h00000001);
        apb(1'b1, `FG_BASE + 8'h18, 32'h00008001);
        apb(1'b1, `FG_LAST, 32'h00004000);
        apb(1'b1, `CFG_LAST, b(`G_CASCADE) | ({30'h0, `MODE_SHIFT} << `G_MODE_LO));
        chk("shift_out", 32'h0, {31'h0, shift_out});
        slice_we <= 4'h8;
        pulse(4'h8);
        slice_we <= 4'h0;
        chk("shift_out", 32'h1, {31'h0, shift_out});
        rchk(`FG_LAST, 32'h00008001);
        carry_in <= 2'h2;
        @(posedge pclk);
        chk("carry_out", 32'h2, {30'h0, carry_out});
        carry_in <= 2'h0;
        @(posedge pclk);
        chk("carry_out", 32'h0, {30'h0, carry_out});
        chk("wide", 32'h0, {31'h0, wide_f7_out});
        second_direct_input <= 4'h2;
        @(posedge pclk);
        chk("wide", 32'h1, {31'h0, wide_f7_out});
        second_direct_input <= 4'h0;
        first_direct_input <= 4'h0;
        @(posedge pclk);
        chk("wide", 32'h1, {31'h0, wide_f7_out});
        $display("chain test done");
        report_and_stop();
    end
endmodule

bind logic_cluster logic_cluster_properties u_props (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .f_in(f_in), .first_direct_input(first_direct_input),
    .second_direct_input(second_direct_input), .slice_clk(slice_clk), .slice_ce(slice_ce),
    .set_reset_input(set_reset_input), .global_init(global_init), .out_x(out_x), .q_x(q_x));
